/* core/trsp_dev.sv */
// Purpose: presents buffered packets as a 128-bit receive stream
// Assumes: a packet is written whole into its queue before it is shown
// Notes: packets longer than the queue depth never start
`include "trsp_cfg.svh"
module trsp_dev #(
  parameter bit CREDIT_MODE = 1'b0,
  parameter int DEPTH = `TRSP_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic ce,
  trsp_if.dev lnk,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [127:0] in_data,
  input wire logic in_last,
  input wire logic [1:0] in_ndw,
  input wire logic in_nonposted
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 4 || DEPTH > 64) begin : g_chk
    $error("trsp_dev queue depth must lie in 4 to 64");
  end

  trsp_pkg::trsp_dstate_t st;
  trsp_pkg::trsp_dstate_t next_st;
  trsp_pkg::trsp_entry_t h [2];
  trsp_pkg::trsp_entry_t h2 [2];
  trsp_pkg::trsp_entry_t cand [2];
  trsp_pkg::trsp_entry_t c;
  trsp_pkg::trsp_entry_t e;
  logic hv [2];
  logic h2v [2];
  logic wr_rdy [2];
  logic push [2];
  logic pop1 [2];
  logic pop2 [2];
  logic cv [2];
  logic [AW:0] pkts [2];
  logic [6:0] seq;
  logic o_valid;
  logic next_valid;
  logic [127:0] o_data;
  logic [127:0] next_data;
  logic [4:0] rx_start_marker;
  logic [4:0] next_start;
  logic [4:0] rx_end_marker;
  logic [4:0] next_end;
  logic cur_q;
  logic next_cur;
  logic [63:0] carry;
  logic [63:0] next_carry;
  logic spill_ndw;
  logic next_spill_ndw;
  logic adv;
  logic straddle;
  logic np_start;
  logic np_ok;
  logic [1:0] sel;
  logic [1:0] after_cnt;
  logic [3:0] credit_cnt;

  // older candidate wins; non-posted only when the throttle permits
  function automatic logic [1:0] pick(input logic v0, input logic v1,
                                      input logic [6:0] s0,
                                      input logic [6:0] s1,
                                      input logic ok);
    logic e1;
    logic [6:0] d;
    e1 = v1 && ok;
    d = s1 - s0;
    if (v0 && e1) begin
      pick = {1'b1, d[6]};
    end else if (v0) begin
      pick = 2'b10;
    end else if (e1) begin
      pick = 2'b11;
    end else begin
      pick = 2'b00;
    end
  endfunction : pick

  assign in_ready = in_nonposted ? wr_rdy[1] : wr_rdy[0];
  assign adv = ce && (!o_valid || lnk.tready);

  // queue 0 holds posted and completions, queue 1 non-posted
  for (genvar q = 0; q < 2; q++) begin : g_q
    assign push[q] = ce && in_valid && wr_rdy[q] && (in_nonposted == q);
    trsp_fifo #(
      .WIDTH($bits(trsp_pkg::trsp_entry_t)),
      .DEPTH(DEPTH)
    ) u_fifo (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .wr_valid(in_valid && (in_nonposted == q)),
      .wr_ready(wr_rdy[q]),
      .wr_data({in_data, in_last, in_ndw, seq}),
      .rd_valid(hv[q]),
      .rd_ready(pop1[q]),
      .rd_data(h[q]),
      .rd_valid2(h2v[q]),
      .rd_take2(pop2[q]),
      .rd_data2(h2[q]),
      .level()
    );
    // count only packets stored whole, so valid never gaps
    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        pkts[q] <= '0;
      end else if (ce) begin
        pkts[q] <= pkts[q] + (AW+1)'(push[q] && in_last)
                   - (AW+1)'(pop2[q] ? {1'b0, h[q].last} + {1'b0, h2[q].last}
                              : {1'b0, pop1[q] && h[q].last});
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      seq <= '0;
    end else if (push[0] || push[1]) begin
      seq <= seq + 7'(in_last);
    end
  end

  always_comb begin
    np_ok = CREDIT_MODE ? (credit_cnt != 4'h0)
          : (lnk.nonposted_accept_allow
             || after_cnt < `TRSP_NP_AFTER_DROP);
    for (int q = 0; q < 2; q++) begin
      cand[q] = h[q];
      cv[q] = pkts[q] != '0;
    end
    if (st == trsp_pkg::st_run) begin
      cand[cur_q] = h2[cur_q];
      cv[cur_q] = pkts[cur_q] > (AW+1)'(1);
    end
    sel = pick(cv[0], cv[1], cand[0].seq, cand[1].seq, np_ok);
    c = cand[sel[0]];
    e = h[cur_q];
  end

  always_comb begin
    next_st = st;
    next_valid = o_valid;
    next_data = o_data;
    next_start = rx_start_marker;
    next_end = rx_end_marker;
    next_cur = cur_q;
    next_carry = carry;
    next_spill_ndw = spill_ndw;
    straddle = 1'b0;
    np_start = 1'b0;
    for (int q = 0; q < 2; q++) begin
      pop1[q] = 1'b0;
      pop2[q] = 1'b0;
    end
    if (adv) begin
      next_valid = 1'b0;
      next_start = 5'h00;
      next_end = 5'h00;
      case (st)
        trsp_pkg::st_idle: begin
          if (sel[1]) begin
            next_data = c.data;
            next_start = `TRSP_SOF_AT0;
            next_valid = 1'b1;
            pop1[sel[0]] = 1'b1;
            np_start = sel[0];
            next_cur = sel[0];
            next_st = trsp_pkg::st_run;
            if (c.last) begin
              next_end = {1'b1, c.ndw, `TRSP_EOF_LOW};
              next_st = trsp_pkg::st_idle;
            end
          end
        end
        trsp_pkg::st_run: begin
          next_data = e.data;
          next_valid = 1'b1;
          pop1[cur_q] = 1'b1;
          if (e.last) begin
            next_end = {1'b1, e.ndw, `TRSP_EOF_LOW};
            next_st = trsp_pkg::st_idle;
            straddle = !e.ndw[1] && sel[1];
          end
        end
        trsp_pkg::st_shift: begin
          next_data = {e.data[63:0], carry};
          next_carry = e.data[127:64];
          next_valid = 1'b1;
          pop1[cur_q] = 1'b1;
          if (e.last && !e.ndw[1]) begin
            next_end = {2'b11, e.ndw[0], `TRSP_EOF_LOW};
            next_st = trsp_pkg::st_idle;
          end else if (e.last) begin
            next_spill_ndw = e.ndw[0];
            next_st = trsp_pkg::st_spill;
          end
        end
        trsp_pkg::st_spill: begin
          next_data = {64'h0, carry};
          next_end = {2'b10, spill_ndw, `TRSP_EOF_LOW};
          next_valid = 1'b1;
          next_st = trsp_pkg::st_idle;
          straddle = sel[1];
        end
        default: begin
          next_st = trsp_pkg::st_idle;
        end
      endcase
      // new packet enters the upper half, rest realigned by 64 bits
      if (straddle) begin
        next_data[127:64] = c.data[63:0];
        next_carry = c.data[127:64];
        next_start = `TRSP_SOF_AT8;
        np_start = sel[0];
        next_cur = sel[0];
        next_st = trsp_pkg::st_shift;
        if (st == trsp_pkg::st_run && sel[0] == cur_q) begin
          pop1[cur_q] = 1'b0;
          pop2[cur_q] = 1'b1;
        end else begin
          pop1[sel[0]] = 1'b1;
        end
        if (c.last) begin
          next_spill_ndw = c.ndw[0];
          next_st = trsp_pkg::st_spill;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st <= trsp_pkg::st_idle;
      o_valid <= 1'b0;
      o_data <= 128'h0;
      rx_start_marker <= 5'h00;
      rx_end_marker <= 5'h00;
      cur_q <= 1'b0;
      carry <= 64'h0;
      spill_ndw <= 1'b0;
    end else if (ce) begin
      st <= next_st;
      o_valid <= next_valid;
      o_data <= next_data;
      rx_start_marker <= next_start;
      rx_end_marker <= next_end;
      cur_q <= next_cur;
      carry <= next_carry;
      spill_ndw <= next_spill_ndw;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      after_cnt <= 2'h0;
    end else if (ce) begin
      if (lnk.nonposted_accept_allow) begin
        after_cnt <= 2'h0;
      end else if (np_start && !CREDIT_MODE) begin
        after_cnt <= after_cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      credit_cnt <= 4'h0;
    end else if (ce && CREDIT_MODE) begin
      credit_cnt <= credit_cnt
                    + 4'(lnk.nonposted_credit_request
                         && credit_cnt < `TRSP_CREDIT_MAX)
                    - 4'(np_start);
    end
  end

  always_comb begin
    lnk.tuser = '0;
    lnk.tuser[`TRSP_SOF_MSB -: 5] = rx_start_marker;
    lnk.tuser[`TRSP_EOF_MSB -: 5] = rx_end_marker;
  end
  assign lnk.tvalid = o_valid;
  assign lnk.tdata = o_data;
endmodule : trsp_dev

/* core/trsp_cfg.svh */
// Purpose: shared constants of the receive stream presenter and its sink
// Assumes: 128-bit data beats, 22-bit sideband word
// Notes: field positions are bit indices into the sideband word
`ifndef TRSP_CFG_SVH
`define TRSP_CFG_SVH
`define TRSP_SOF_MSB 14
`define TRSP_EOF_MSB 21
`define TRSP_USER_W 22
`define TRSP_SOF_AT0 5'h10
`define TRSP_SOF_AT8 5'h18
`define TRSP_EOF_LOW 2'h3
`define TRSP_CREDIT_MAX 4'hc
`define TRSP_NP_AFTER_DROP 2'h2
`define TRSP_FIFO_DEPTH 32
`define TRSP_SINK_DEPTH 4
`define TRSP_NP_LOW_MARK 3
`define TRSP_NP_BUF 8
`endif

/* core/trsp_pkg.sv */
// Purpose: types shared by both ends of the receive stream
// Assumes: nothing beyond the constants header
// Notes: entries are whole beats of one packet
package trsp_pkg;
  typedef struct packed {
    logic [127:0] data;
    logic last;
    logic [1:0] ndw;
    logic [6:0] seq;
  } trsp_entry_t;

  typedef struct packed {
    logic [127:0] data;
    logic [4:0] rx_start_marker;
    logic [4:0] rx_end_marker;
  } trsp_beat_t;

  typedef enum logic [1:0] {
    st_idle,
    st_run,
    st_shift,
    st_spill
  } trsp_dstate_t;

  typedef enum logic {
    hs_whole,
    hs_head
  } trsp_hstate_t;
endpackage : trsp_pkg

/* core/trsp_if.sv */
// Purpose: link between presenter and user sink
// Assumes: both ends on sys_clk
// Notes: sideband markers meaningful only with tvalid
interface trsp_if;
  logic [127:0] tdata;
  logic tvalid;
  logic tready;
  logic [21:0] tuser;
  logic nonposted_accept_allow;
  logic nonposted_credit_request;
  modport dev (
    output tdata,
    output tvalid,
    output tuser,
    input tready,
    input nonposted_accept_allow,
    input nonposted_credit_request
  );
  modport usr (
    input tdata,
    input tvalid,
    input tuser,
    output tready,
    output nonposted_accept_allow,
    output nonposted_credit_request
  );
endinterface : trsp_if

/* core/trsp_fifo.sv */
// Purpose: beat buffer with single or double pop
// Assumes: depth a power of two
// Notes: second word peek lets a straddle take two entries
`include "trsp_cfg.svh"
module trsp_fifo #(
  parameter int WIDTH = 138,
  parameter int DEPTH = `TRSP_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data,
  output logic rd_valid2,
  input wire logic rd_take2,
  output logic [WIDTH-1:0] rd_data2,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_chk
    $error("trsp_fifo depth must be a power of two of at least 4");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic push;
  logic [AW:0] npop;
  logic [AW:0] next_level;

  assign push = ce && wr_valid && wr_ready;
  assign rd_valid = level != '0;
  assign rd_valid2 = level > (AW+1)'(1);
  assign rd_data = mem[rp];
  assign rd_data2 = mem[rp + 1'b1];

  always_comb begin
    npop = '0;
    if (ce && rd_take2 && rd_valid2) begin
      npop = (AW+1)'(2);
    end else if (ce && rd_ready && rd_valid) begin
      npop = (AW+1)'(1);
    end
    next_level = level + {{AW{1'b0}}, push} - npop;
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wp] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wp <= '0;
      rp <= '0;
    end else if (ce) begin
      wp <= wp + {{(AW-1){1'b0}}, push};
      rp <= rp + npop[AW-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      level <= '0;
      wr_ready <= 1'b1;
    end else if (ce) begin
      level <= next_level;
      wr_ready <= next_level < FULL;
    end
  end
endmodule : trsp_fifo

/* core/trsp_usr.sv */
// Purpose: user-side sink that splits straddled beats into packet beats
// Assumes: non-posted buffer of NP_BUF packets released by np_release
// Notes: tready is registered, so it drops two entries short of full and the buffer keeps one spare entry
`include "trsp_cfg.svh"
module trsp_usr #(
  parameter bit CREDIT_MODE = 1'b0,
  parameter int DEPTH = `TRSP_SINK_DEPTH,
  parameter int NP_BUF = `TRSP_NP_BUF
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic ce,
  trsp_if.usr lnk,
  output logic out_valid,
  input wire logic out_ready,
  output logic [127:0] out_data,
  output logic out_first,
  output logic out_upper,
  output logic out_last,
  output logic [1:0] out_last_dw,
  output logic out_nonposted,
  input wire logic np_release,
  input wire logic credit_pulse
);
  localparam int AW = $clog2(DEPTH);
  if (NP_BUF <= `TRSP_NP_LOW_MARK || NP_BUF > 255) begin : g_chk
    $error("trsp_usr non-posted buffer must hold 4 to 255");
  end
  trsp_pkg::trsp_beat_t b;
  trsp_pkg::trsp_hstate_t hs;
  logic rd_valid;
  logic pop;
  logic [AW:0] level;
  logic tready_r;
  logic oadv;
  logic strad;
  logic np_seen;
  logic [7:0] avail;
  logic [7:0] next_avail;

  function automatic logic is_np(input logic [31:0] hdr);
    if (hdr[28:25] == 4'h0) begin
      is_np = !hdr[30];
    end else begin
      is_np = hdr[28:24] == 5'h02 || hdr[28:25] == 4'h2;
    end
  endfunction : is_np

  trsp_fifo #(
    .WIDTH($bits(trsp_pkg::trsp_beat_t)),
    .DEPTH(DEPTH)
  ) u_buf (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .wr_valid(lnk.tvalid && tready_r),
    .wr_ready(),
    .wr_data({lnk.tdata, lnk.tuser[`TRSP_SOF_MSB -: 5],
              lnk.tuser[`TRSP_EOF_MSB -: 5]}),
    .rd_valid(rd_valid),
    .rd_ready(pop),
    .rd_data(b),
    .rd_valid2(),
    .rd_take2(1'b0),
    .rd_data2(),
    .level(level)
  );

  assign lnk.tready = tready_r;
  assign oadv = ce && (!out_valid || out_ready);
  assign strad = b.rx_start_marker[4] && b.rx_end_marker[4]
                 && b.rx_start_marker[3];
  assign pop = oadv && rd_valid && !(hs == trsp_pkg::hs_whole && strad);
  assign np_seen = lnk.tvalid && tready_r && lnk.tuser[`TRSP_SOF_MSB]
                   && is_np(lnk.tuser[`TRSP_SOF_MSB-1] ? lnk.tdata[95:64]
                                                       : lnk.tdata[31:0]);
  assign next_avail = avail - 8'(np_seen)
                      + 8'(np_release && avail < 8'(NP_BUF));

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tready_r <= 1'b0;
    end else if (ce) begin
      tready_r <= level < (AW+1)'(DEPTH - 2);
    end
  end

  // straddle: tail of old packet first, then the new one from byte 8
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hs <= trsp_pkg::hs_whole;
      out_valid <= 1'b0;
      out_data <= 128'h0;
      out_first <= 1'b0;
      out_upper <= 1'b0;
      out_last <= 1'b0;
      out_last_dw <= 2'h0;
      out_nonposted <= 1'b0;
    end else if (oadv) begin
      out_valid <= rd_valid;
      if (rd_valid) begin
        out_data <= b.data;
        out_last_dw <= b.rx_end_marker[3:2];
        if (hs == trsp_pkg::hs_whole && strad) begin
          out_first <= 1'b0;
          out_upper <= 1'b0;
          out_last <= 1'b1;
          out_nonposted <= 1'b0;
          hs <= trsp_pkg::hs_head;
        end else begin
          out_first <= b.rx_start_marker[4];
          out_upper <= b.rx_start_marker[3];
          out_last <= b.rx_end_marker[4] && !strad;
          out_nonposted <= b.rx_start_marker[4]
                           && is_np(b.rx_start_marker[3] ? b.data[95:64]
                                                         : b.data[31:0]);
          hs <= trsp_pkg::hs_whole;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      avail <= 8'(NP_BUF);
      lnk.nonposted_accept_allow <= 1'b1;
      lnk.nonposted_credit_request <= 1'b0;
    end else if (ce) begin
      avail <= next_avail;
      lnk.nonposted_accept_allow <= CREDIT_MODE
        || next_avail > 8'(`TRSP_NP_LOW_MARK);
      lnk.nonposted_credit_request <= CREDIT_MODE && credit_pulse;
    end
  end
endmodule : trsp_usr

/* verification/trsp_chk_sva.sv */
// Purpose: protocol checks on the receive stream link
// Assumes: accept-allow mode, one clock
// Notes: a non-posted start is read from the header format bit
module trsp_chk (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [127:0] tdata,
  input wire logic tvalid,
  input wire logic tready,
  input wire logic [21:0] tuser,
  input wire logic nonposted_accept_allow,
  input wire logic nonposted_credit_request
);
  timeunit 1ns;
  timeprecision 1ps;
  logic open_pkt;
  logic allow_q;
  logic [2:0] np_cnt;
  logic take;
  logic np_start;
  assign take = tvalid && tready;
  assign np_start = take && tuser[14] && !(tuser[13] ? tdata[94] : tdata[30]);
  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      open_pkt <= 1'b0;
    else if (take && tuser[14])
      open_pkt <= !(tuser[21] && !tuser[13]);
    else if (take && tuser[21])
      open_pkt <= 1'b0;
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      allow_q <= 1'b1;
    else
      allow_q <= nonposted_accept_allow;
  end
  // counts starts from the edge after allow was first seen low
  always_ff @(posedge sys_clk) begin
    if (sys_rst || allow_q)
      np_cnt <= 3'h0;
    else if (np_start && np_cnt != 3'h7)
      np_cnt <= np_cnt + 3'h1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence stall_s;
    tvalid && !tready;
  endsequence
  sequence held_s;
    tvalid && $stable(tdata) && $stable(tuser);
  endsequence
  hold_stall_a: assert property (stall_s |=> held_s)
    else $error("beat changed while stalled");
  valid_in_pkt_a: assert property (open_pkt |-> tvalid)
    else $error("valid dropped inside a packet");
  sof_code_a: assert property (tvalid && tuser[14] |->
    tuser[13:10] == 4'h0 || tuser[13:10] == 4'h8)
    else $error("bad start position");
  eof_code_a: assert property (tvalid && tuser[21] |->
    tuser[18:17] == 2'b11)
    else $error("bad end byte");
  straddle_ends_a: assert property (tvalid && tuser[14] && tuser[13] |->
    tuser[21] && !tuser[20])
    else $error("upper start without low end");
  last_beat_a: assert property (tvalid && tuser[21] && !tuser[14] |->
    open_pkt)
    else $error("end without open packet");
  no_restart_a: assert property (tvalid && tuser[14] && !tuser[13] |->
    !open_pkt)
    else $error("start inside open packet");
  np_limit_a: assert property (np_cnt <= 3'h2)
    else $error("too many non-posted after allow low");
endmodule : trsp_chk

/* verification/test_tlp_rx_stream_presenter.sv */
// Purpose: end-to-end bench of presenter and sink over the link
// Assumes: accept-allow mode, default depths
// Notes: link beats are logged at each take and judged per test
module test_tlp_rx_stream_presenter;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic in_valid = 1'b0;
  logic in_ready;
  logic [127:0] in_data = 128'h0;
  logic in_last = 1'b0;
  logic [1:0] in_ndw = 2'h0;
  logic in_np = 1'b0;
  logic out_valid;
  logic out_ready = 1'b1;
  logic out_last;
  logic out_upper;
  logic np_release = 1'b0;
  logic credit_pulse = 1'b0;
  int error_cnt = 0;
  int total_checks = 0;
  int pkt_no = 0;
  int pkt_out = 0;
  int up_out = 0;
  logic [21:0] lg_user[$];
  logic [127:0] lg_data[$];
  trsp_if trsp_if_i ();
  trsp_dev trsp_dev_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .ce(ce), .lnk(trsp_if_i),
    .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
    .in_last(in_last), .in_ndw(in_ndw), .in_nonposted(in_np)
  );
  trsp_usr trsp_usr_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .ce(ce), .lnk(trsp_if_i),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(),
    .out_first(), .out_upper(out_upper), .out_last(out_last),
    .out_last_dw(),
    .out_nonposted(), .np_release(np_release), .credit_pulse(credit_pulse)
  );
  trsp_chk trsp_chk_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .tdata(trsp_if_i.tdata),
    .tvalid(trsp_if_i.tvalid), .tready(trsp_if_i.tready),
    .tuser(trsp_if_i.tuser),
    .nonposted_accept_allow(trsp_if_i.nonposted_accept_allow),
    .nonposted_credit_request(trsp_if_i.nonposted_credit_request)
  );
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (!sys_rst && trsp_if_i.tvalid && trsp_if_i.tready) begin
      lg_user.push_back(trsp_if_i.tuser);
      lg_data.push_back(trsp_if_i.tdata);
    end
    if (!sys_rst && out_valid && out_ready && out_last)
      pkt_out++;
    if (!sys_rst && out_valid && out_ready && out_upper)
      up_out++;
  end
  function automatic logic [21:0] mk(logic [4:0] sof, logic [4:0] eof);
    return {eof, 2'b00, sof, 10'h000};
  endfunction : mk
  function automatic logic [127:0] bdat(int p, int b, logic [7:0] hdr);
    logic [127:0] d;
    d = {4{8'h5a, 8'(p), 8'(b), 8'h00}};
    if (b == 0)
      d[31:24] = hdr;
    return d;
  endfunction : bdat
  function automatic int count_kind(logic posted);
    int c = 0;
    foreach (lg_user[i])
      if (lg_user[i][14] && lg_data[i][30] == posted)
        c++;
    return c;
  endfunction : count_kind
  task automatic chk_user(logic [21:0] got, logic [21:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_user
  task automatic chk_val(logic [127:0] got, logic [127:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict
  task automatic timeout_hit(int got, int exp);
    chk_val(128'(got), 128'(exp));
    print_verdict();
  endtask : timeout_hit
  task automatic clear_log();
    lg_user.delete();
    lg_data.delete();
  endtask : clear_log
  task automatic send_pkt(int dw, logic [7:0] hdr, logic np);
    int nb;
    int n;
    logic ok;
    nb = (dw + 3) / 4;
    for (int b = 0; b < nb; b++) begin
      in_valid <= 1'b1;
      in_data <= bdat(pkt_no, b, hdr);
      in_last <= (b == nb - 1);
      in_ndw <= 2'(dw - 1 - 4 * b);
      in_np <= np;
      n = 0;
      do begin
        @(negedge sys_clk);
        ok = in_ready;
        @(posedge sys_clk);
        n++;
      end while (ok !== 1'b1 && n < 300);
      if (ok !== 1'b1)
        timeout_hit(n, 0);
    end
    in_valid <= 1'b0;
    pkt_no++;
    @(posedge sys_clk);
  endtask : send_pkt
  task automatic wait_link(int n);
    int k;
    for (k = 0; k < 500 && lg_user.size() < n; k++)
      @(posedge sys_clk);
    if (lg_user.size() < n)
      timeout_hit(lg_user.size(), n);
    repeat (2) @(posedge sys_clk);
  endtask : wait_link
  task automatic s_ends();
    logic [127:0] m;
    logic [127:0] d;
    for (int k = 0; k < 4; k++) begin
      clear_log();
      d = bdat(pkt_no, 1, 8'h40);
      send_pkt(5 + k, 8'h40, 1'b0);
      wait_link(2);
      m = (128'h1 << (32 * (k + 1))) - 128'h1;
      chk_user(lg_user[0], mk(5'h10, 5'h00));
      chk_user(lg_user[1], mk(5'h00, {1'b1, 2'(k), 2'b11}));
      chk_val(lg_data[1] & m, d & m);
      chk_val(128'(lg_user.size()), 128'h2);
    end
    $display("test ends done");
  endtask : s_ends
  task automatic s_straddle();
    logic [127:0] h;
    int base;
    int ubase;
    clear_log();
    base = pkt_out;
    ubase = up_out;
    out_ready <= 1'b0;
    repeat (4) send_pkt(3, 8'h40, 1'b0);
    send_pkt(6, 8'h40, 1'b0);
    h = bdat(pkt_no, 0, 8'h40);
    send_pkt(3, 8'h40, 1'b0);
    repeat (20) @(posedge sys_clk);
    chk_val(128'(lg_user.size() < 7), 128'h1);
    out_ready <= 1'b1;
    wait_link(7);
    for (int k = 0; k < 4; k++)
      chk_user(lg_user[k], mk(5'h10, 5'h1b));
    chk_user(lg_user[4], mk(5'h10, 5'h00));
    chk_user(lg_user[5], mk(5'h18, 5'h17));
    chk_user(lg_user[6], mk(5'h00, 5'h13));
    chk_val({64'h0, lg_data[5][127:64]}, {64'h0, h[63:0]});
    chk_val({96'h0, lg_data[6][31:0]}, {96'h0, h[95:64]});
    repeat (10) @(posedge sys_clk);
    chk_val(128'(pkt_out - base), 128'h6);
    chk_val(128'(up_out - ubase), 128'h1);
    $display("test straddle done");
  endtask : s_straddle
  task automatic s_np();
    int np;
    int k;
    clear_log();
    repeat (10) send_pkt(3, 8'h00, 1'b1);
    repeat (2) send_pkt(4, 8'h40, 1'b0);
    for (k = 0; k < 300 && count_kind(1'b1) < 2; k++)
      @(posedge sys_clk);
    if (count_kind(1'b1) < 2)
      timeout_hit(count_kind(1'b1), 2);
    np = count_kind(1'b0);
    chk_val(128'(np <= 7 && np >= 5), 128'h1);
    chk_val(128'(lg_user.size()), 128'(np + 2));
    repeat (np) begin
      np_release <= 1'b1;
      @(posedge sys_clk);
      np_release <= 1'b0;
      @(posedge sys_clk);
    end
    send_pkt(4, 8'h40, 1'b0);
    wait_link(13);
    chk_val(128'(count_kind(1'b0)), 128'ha);
    chk_val({127'h0, lg_data[12][30]}, 128'h1);
    $display("test nonposted done");
  endtask : s_np
  task automatic s_fill();
    int taken;
    logic ok;
    clear_log();
    taken = 0;
    out_ready <= 1'b0;
    in_valid <= 1'b1;
    in_data <= bdat(0, 0, 8'h40);
    in_last <= 1'b1;
    in_ndw <= 2'h3;
    in_np <= 1'b0;
    for (int k = 0; k < 80; k++) begin
      @(negedge sys_clk);
      ok = in_ready;
      @(posedge sys_clk);
      if (ok === 1'b1)
        taken++;
    end
    in_valid <= 1'b0;
    chk_val(128'(taken >= 32 && taken < 80), 128'h1);
    out_ready <= 1'b1;
    wait_link(taken);
    repeat (5) @(posedge sys_clk);
    chk_val(128'(lg_user.size()), 128'(taken));
    chk_val({127'h0, trsp_if_i.tvalid}, 128'h0);
    $display("test fill done");
  endtask : s_fill
  initial begin
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    s_ends();
    s_straddle();
    s_np();
    s_fill();
    print_verdict();
  end
endmodule : test_tlp_rx_stream_presenter
